// ---- hdl/rssm_consts.svh ----
// Purpose: Constants for the receive signal strength monitor
// Assumes: 10 MHz system clock
// Notes:   Timing counts are in reference clock cycles
`ifndef RSSM_CONSTS_SVH
`define RSSM_CONSTS_SVH
`define RSSM_MODE_RX        3'h3
`define RSSM_GAIN_RESET     2'h0
`define RSSM_SAMPLES        16
`define RSSM_DEV_DIV_BASE   32
`define RSSM_FIFO_DEPTH     16
`define RSSM_FIFO_WIDTH     8
`define RSSM_BIT_DIV_BASE   64
`endif

// ---- hdl/rssm_fifo.sv ----
// Purpose: Receive bit buffer
// Assumes: One clock
// Notes:   Flip-flop storage
`timescale 1ns/10ps
`default_nettype none
module rssm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data  = mem_q[rd_q];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- hdl/rssm_pkg.sv ----
// Purpose: Types for the receive signal strength monitor
// Assumes: Nothing
// Notes:   One-hot data path selection
package rssm_pkg;
    typedef enum logic [2:0] {
        RSSM_PATH_RAW  = 3'b001,
        RSSM_PATH_SYNC = 3'b010,
        RSSM_PATH_BUF  = 3'b100
    } rssm_path_type;
endpackage

// ---- hdl/rssm_top.sv ----
// Purpose: Signal strength sampling, threshold status, demodulated data path
// Assumes: Strength samples digitised in 0.5 dB steps; I/Q signs arrive as pins
// Notes:   Sample tick derived from deviation field
`timescale 1ns/10ps
`default_nettype none
`include "rssm_consts.svh"
module rssm_top
    import rssm_pkg::*;
(
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RESET_N,
    input  wire logic [2:0]  I_OPERATING_MODE_FIELD,
    input  wire logic [1:0]  I_IF_AMP_GAIN_SELECT,
    input  wire logic        I_IF_GAIN_WRITE,
    input  wire logic        I_COMPLEX_FILTER_ENABLE,
    input  wire logic [7:0]  I_FREQ_DEVIATION_FIELD,
    input  wire logic [7:0]  I_LEVEL_SAMPLE,
    input  wire logic        I_I_SIGN,
    input  wire logic        I_Q_SIGN,
    input  wire logic [7:0]  I_STRENGTH_IRQ_THRESHOLD,
    input  wire logic        I_STRENGTH_IRQ_CLEAR,
    input  wire logic        I_IRQ_ROUTE_PIN_A,
    input  wire logic        I_IRQ_ROUTE_PIN_B,
    input  wire logic        I_CONTINUOUS_MODE,
    input  wire logic        I_RAW_SELECT,
    input  wire logic [7:0]  I_BIT_RATE_FIELD,
    input  wire logic        I_BUF_READ,
    output logic             O_RX_ACTIVE,
    output logic [1:0]       O_IF_GAIN,
    output logic             O_POLYPHASE_ON,
    output logic             O_LOWPASS_ON,
    output logic [7:0]       O_SIGNAL_STRENGTH_RESULT,
    output logic             O_STRENGTH_IRQ_STATUS,
    output logic             O_INTERRUPT_PIN_A,
    output logic             O_INTERRUPT_PIN_B,
    output logic             O_DATA,
    output logic             O_DCLK,
    output logic             O_BUF_VALID,
    output logic [7:0]       O_BUF_DATA
);
    // ******************************
    // Input synchronisers
    // ******************************
    logic [7:0]  lvl_s1_q;
    logic [7:0]  lvl_s2_q;
    logic [1:0]  iq_s1_q;
    logic [1:0]  iq_s2_q;

    always_ff @(posedge I_CLK_SYS)
    begin
        lvl_s1_q <= I_LEVEL_SAMPLE;
        lvl_s2_q <= lvl_s1_q;
        iq_s1_q  <= {I_I_SIGN, I_Q_SIGN};
        iq_s2_q  <= iq_s1_q;
    end

    // ******************************
    // Mode, gain and filter control
    // ******************************
    logic [1:0]  gain_q;
    logic        rx_on;

    assign rx_on          = (I_OPERATING_MODE_FIELD == `RSSM_MODE_RX);
    assign O_RX_ACTIVE    = rx_on;
    assign O_IF_GAIN      = gain_q;
    assign O_POLYPHASE_ON = I_COMPLEX_FILTER_ENABLE;
    assign O_LOWPASS_ON   = !I_COMPLEX_FILTER_ENABLE;

    // Code 0 is 0 dB, each step lowers gain by 4.5 dB
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            gain_q <= `RSSM_GAIN_RESET;
        end
        else if (I_IF_GAIN_WRITE)
        begin
            gain_q <= I_IF_AMP_GAIN_SELECT;
        end
    end

    // ******************************
    // Sample tick
    // ******************************
    // Deviation period is 32*(1+dev) reference cycles; 16 samples -> 2*(1+dev)
    logic [9:0]  tick_cnt_q;
    logic [9:0]  tick_max;
    logic        tick;

    assign tick_max = 10'({I_FREQ_DEVIATION_FIELD, 1'b1});
    assign tick     = rx_on && (tick_cnt_q >= tick_max);

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N || !rx_on || tick)
        begin
            tick_cnt_q <= 10'h000;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 10'h001;
        end
    end

    // ******************************
    // Moving average
    // ******************************
    logic [7:0]  win_q [`RSSM_SAMPLES];
    logic [11:0] sum_q;
    logic [7:0]  result_q;

    // Window must start at zero, or the running sum picks up unknowns
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            win_q[0] <= 8'h00;
        end
        else if (tick)
        begin
            win_q[0] <= lvl_s2_q;
        end
    end

    genvar g;
    generate
        for (g = 1; g < `RSSM_SAMPLES; g++)
        begin : g_win
            always_ff @(posedge I_CLK_SYS)
            begin
                if (!I_RESET_N)
                begin
                    win_q[g] <= 8'h00;
                end
                else if (tick)
                begin
                    win_q[g] <= win_q[g-1];
                end
            end
        end
    endgenerate

    // Window and sum start at zero so the first fifteen results ramp up
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            sum_q    <= 12'h000;
            result_q <= 8'h00;
        end
        else if (tick)
        begin
            sum_q    <= sum_q + 12'(lvl_s2_q) - 12'(win_q[`RSSM_SAMPLES-1]);
            result_q <= 8'((sum_q + 12'(lvl_s2_q) - 12'(win_q[`RSSM_SAMPLES-1])) >> 4);
        end
    end

    // Result reads zero until the first sample has landed
    logic        filled_q;
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            filled_q <= 1'b0;
        end
        else if (tick)
        begin
            filled_q <= 1'b1;
        end
    end

    assign O_SIGNAL_STRENGTH_RESULT = filled_q ? result_q : 8'h00;

    // ******************************
    // Threshold status
    // ******************************
    logic        status_q;
    logic        upd_q;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            upd_q <= 1'b0;
        end
        else
        begin
            upd_q <= tick;
        end
    end

    // Set wins over a simultaneous clear so no crossing is lost
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            status_q <= 1'b0;
        end
        else if (upd_q && (result_q > I_STRENGTH_IRQ_THRESHOLD))
        begin
            status_q <= 1'b1;
        end
        else if (I_STRENGTH_IRQ_CLEAR)
        begin
            status_q <= 1'b0;
        end
    end

    assign O_STRENGTH_IRQ_STATUS = status_q;
    assign O_INTERRUPT_PIN_A     = status_q && I_IRQ_ROUTE_PIN_A;
    assign O_INTERRUPT_PIN_B     = status_q && I_IRQ_ROUTE_PIN_B;

    // ******************************
    // FSK demodulator and bit sync
    // ******************************
    // Polarity from which of I and Q leads, sampled at each tick
    logic [1:0]  iq_prev_q;
    logic        raw_q;
    logic        raw_d;

    always_comb
    begin
        raw_d = raw_q;
        if (iq_s2_q != iq_prev_q)
        begin
            raw_d = (iq_s2_q[1] ^ iq_prev_q[0]) ^ 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            iq_prev_q <= 2'b00;
            raw_q     <= 1'b0;
        end
        else if (tick)
        begin
            iq_prev_q <= iq_s2_q;
            raw_q     <= raw_d;
        end
    end

    // Bit period 64*(1+br) cycles; edges realign the phase counter
    logic [13:0] bit_cnt_q;
    logic [13:0] bit_max;
    logic        raw_last_q;
    logic        sync_q;
    logic        dclk_q;
    logic        bit_stb;

    assign bit_max = 14'({I_BIT_RATE_FIELD, 6'h3F});
    assign bit_stb = (bit_cnt_q == (bit_max >> 1));

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            bit_cnt_q  <= 14'h0000;
            raw_last_q <= 1'b0;
            sync_q     <= 1'b0;
            dclk_q     <= 1'b0;
        end
        else
        begin
            raw_last_q <= raw_q;
            if (raw_q != raw_last_q || bit_cnt_q >= bit_max)
            begin
                bit_cnt_q <= 14'h0000;
            end
            else
            begin
                bit_cnt_q <= bit_cnt_q + 14'h0001;
            end
            if (bit_stb)
            begin
                sync_q <= raw_q;
            end
            dclk_q <= (bit_cnt_q >= (bit_max >> 1));
        end
    end

    // ******************************
    // Data path and buffer
    // ******************************
    rssm_path_type path;
    logic [7:0]  shf_q;
    logic [2:0]  nb_q;
    logic        byte_v_q;
    logic        fifo_rdy;
    logic        data_q;

    always_comb
    begin
        if (!I_CONTINUOUS_MODE)
        begin
            path = RSSM_PATH_BUF;
        end
        else if (I_RAW_SELECT)
        begin
            path = RSSM_PATH_RAW;
        end
        else
        begin
            path = RSSM_PATH_SYNC;
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            data_q <= 1'b0;
        end
        else
        begin
            case (path)
                RSSM_PATH_RAW:  data_q <= raw_q;
                RSSM_PATH_SYNC: data_q <= sync_q;
                default:        data_q <= 1'b0;
            endcase
        end
    end

    assign O_DATA = data_q;
    assign O_DCLK = (path == RSSM_PATH_SYNC) && dclk_q;

    // The finished byte waits while the buffer is full; new bits are dropped until it is taken
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            shf_q    <= 8'h00;
            nb_q     <= 3'h0;
            byte_v_q <= 1'b0;
        end
        else
        begin
            if (byte_v_q && fifo_rdy)
            begin
                byte_v_q <= 1'b0;
            end
            if (path == RSSM_PATH_BUF && rx_on && bit_stb && !byte_v_q)
            begin
                shf_q <= {shf_q[6:0], raw_q};
                nb_q  <= nb_q + 3'h1;
                if (nb_q == 3'h7)
                begin
                    byte_v_q <= 1'b1;
                end
            end
        end
    end

    rssm_fifo #(
        .WIDTH (`RSSM_FIFO_WIDTH),
        .DEPTH (`RSSM_FIFO_DEPTH)
    ) u_fifo (
        .i_clk     (I_CLK_SYS),
        .i_reset_n (I_RESET_N),
        .i_valid   (byte_v_q),
        .o_ready   (fifo_rdy),
        .i_data    (shf_q),
        .o_valid   (O_BUF_VALID),
        .i_ready   (I_BUF_READ),
        .o_data    (O_BUF_DATA)
    );
endmodule
`default_nettype wire

// ---- tb/rssm_mcu_model.sv ----
// Purpose: Companion controller settings seen by the monitor
// Assumes: Driven at falling clock edge by the bench
// Notes:   No serial port; settings appear as levels
`timescale 1ns/10ps
`default_nettype none
module rssm_mcu_model (
    input  wire logic       i_ook,
    input  wire logic [7:0] i_dev,
    input  wire logic       i_clear_req,
    output logic [7:0]      o_dev,
    output logic            o_clear
);
    // ****************
    // Settings
    // ****************
    // On-off keying forces the 100 kHz setting
    assign o_dev   = i_ook ? 8'h03 : i_dev;
    assign o_clear = i_clear_req;
endmodule
`default_nettype wire

// ---- tb/rssm_props.sv ----
// Purpose: Port checker for rssm_top
// Assumes: One clock, reset synchronous active low
// Notes:   Bound to every rssm_top
`timescale 1ns/10ps
`default_nettype none
module rssm_props (
    input wire logic       I_CLK_SYS,
    input wire logic       I_RESET_N,
    input wire logic [2:0] I_OPERATING_MODE_FIELD,
    input wire logic [1:0] I_IF_AMP_GAIN_SELECT,
    input wire logic       I_IF_GAIN_WRITE,
    input wire logic       I_COMPLEX_FILTER_ENABLE,
    input wire logic [7:0] I_STRENGTH_IRQ_THRESHOLD,
    input wire logic       I_STRENGTH_IRQ_CLEAR,
    input wire logic       I_IRQ_ROUTE_PIN_A,
    input wire logic       I_IRQ_ROUTE_PIN_B,
    input wire logic       I_BUF_READ,
    input wire logic       O_RX_ACTIVE,
    input wire logic [1:0] O_IF_GAIN,
    input wire logic       O_POLYPHASE_ON,
    input wire logic       O_LOWPASS_ON,
    input wire logic [7:0] O_SIGNAL_STRENGTH_RESULT,
    input wire logic       O_STRENGTH_IRQ_STATUS,
    input wire logic       O_INTERRUPT_PIN_A,
    input wire logic       O_INTERRUPT_PIN_B,
    input wire logic       O_BUF_VALID,
    input wire logic [7:0] O_BUF_DATA
);
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);
    sequence s_gain_wr;
        I_IF_GAIN_WRITE;
    endsequence
    // Update then compare: a fresh result above threshold sets status next cycle
    sequence s_over;
        $changed(O_SIGNAL_STRENGTH_RESULT) && (O_SIGNAL_STRENGTH_RESULT > I_STRENGTH_IRQ_THRESHOLD);
    endsequence
    a_rx_mode: assert property (O_RX_ACTIVE == (I_OPERATING_MODE_FIELD == 3'h3)) else $error("rx flag wrong");
    a_gain_load: assert property (s_gain_wr |=> O_IF_GAIN == $past(I_IF_AMP_GAIN_SELECT)) else $error("gain");
    a_filter_pick: assert property (
        O_POLYPHASE_ON == I_COMPLEX_FILTER_ENABLE && O_LOWPASS_ON != O_POLYPHASE_ON)
        else $error("filter select wrong");
    a_result_quiet: assert property (
        $past(!O_RX_ACTIVE) |-> $stable(O_SIGNAL_STRENGTH_RESULT))
        else $error("result moved outside receive");
    a_status_set: assert property (s_over |=> O_STRENGTH_IRQ_STATUS) else $error("status not set");
    a_status_cause: assert property ($rose(O_STRENGTH_IRQ_STATUS) |->
        $past(O_SIGNAL_STRENGTH_RESULT) > $past(I_STRENGTH_IRQ_THRESHOLD)) else $error("status set early");
    a_status_sticky: assert property (
        O_STRENGTH_IRQ_STATUS && !I_STRENGTH_IRQ_CLEAR |=> O_STRENGTH_IRQ_STATUS)
        else $error("status lost");
    a_pin_a_route: assert property (
        O_INTERRUPT_PIN_A == (O_STRENGTH_IRQ_STATUS && I_IRQ_ROUTE_PIN_A))
        else $error("pin a wrong");
    a_pin_b_route: assert property (
        O_INTERRUPT_PIN_B == (O_STRENGTH_IRQ_STATUS && I_IRQ_ROUTE_PIN_B))
        else $error("pin b wrong");
    a_buf_hold: assert property (
        O_BUF_VALID && !I_BUF_READ |=> O_BUF_VALID && $stable(O_BUF_DATA))
        else $error("buffer output dropped");
endmodule
bind rssm_top rssm_props u_props (.I_CLK_SYS, .I_RESET_N, .I_OPERATING_MODE_FIELD, .I_IF_AMP_GAIN_SELECT,
    .I_IF_GAIN_WRITE, .I_COMPLEX_FILTER_ENABLE, .I_STRENGTH_IRQ_THRESHOLD, .I_STRENGTH_IRQ_CLEAR,
    .I_IRQ_ROUTE_PIN_A, .I_IRQ_ROUTE_PIN_B, .I_BUF_READ, .O_RX_ACTIVE, .O_IF_GAIN, .O_POLYPHASE_ON,
    .O_LOWPASS_ON, .O_SIGNAL_STRENGTH_RESULT, .O_STRENGTH_IRQ_STATUS, .O_INTERRUPT_PIN_A,
    .O_INTERRUPT_PIN_B, .O_BUF_VALID, .O_BUF_DATA);
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for rssm_top
// Assumes: 10 MHz clock, inputs change at falling edge
// Notes:   Buffer test fills past depth before draining
`timescale 1ns/10ps
`default_nettype none
module tb;
    // ****************
    // Bench
    // ****************
    logic       clk = 0, rst_n = 0, gwr = 0, cfe = 0, ra = 0, rb = 0, cont = 0, raw = 0, brd = 0;
    logic       ook = 0, clrq = 0, rev = 0, clr, rxa, pol, low, sts, pa, pb, dat, dclk, bv;
    logic [2:0] mode = 3'h3;
    logic [1:0] gsel = 2'h0, gain;
    logic [4:0] ph = 5'h00;
    logic [7:0] lvl = 8'h00, devt = 8'h00, thr = 8'hFF, dev, res, bd;
    int         bad_count = 0, checks = 0;
    initial forever #50 clk = ~clk;
    always @(negedge clk) ph <= rev ? ph - 5'h01 : ph + 5'h01;
    rssm_mcu_model MCU (.i_ook(ook), .i_dev(devt), .i_clear_req(clrq), .o_dev(dev), .o_clear(clr));
    rssm_top DUT (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_OPERATING_MODE_FIELD(mode), .I_IF_AMP_GAIN_SELECT(gsel),
        .I_IF_GAIN_WRITE(gwr), .I_COMPLEX_FILTER_ENABLE(cfe), .I_FREQ_DEVIATION_FIELD(dev), .I_LEVEL_SAMPLE(lvl),
        .I_I_SIGN(ph[4]), .I_Q_SIGN(ph[4] ^ ph[3]), .I_STRENGTH_IRQ_THRESHOLD(thr), .I_STRENGTH_IRQ_CLEAR(clr),
        .I_IRQ_ROUTE_PIN_A(ra), .I_IRQ_ROUTE_PIN_B(rb), .I_CONTINUOUS_MODE(cont), .I_RAW_SELECT(raw),
        .I_BIT_RATE_FIELD(8'h00), .I_BUF_READ(brd), .O_RX_ACTIVE(rxa), .O_IF_GAIN(gain), .O_POLYPHASE_ON(pol),
        .O_LOWPASS_ON(low), .O_SIGNAL_STRENGTH_RESULT(res), .O_STRENGTH_IRQ_STATUS(sts), .O_INTERRUPT_PIN_A(pa),
        .O_INTERRUPT_PIN_B(pb), .O_DATA(dat), .O_DCLK(dclk), .O_BUF_VALID(bv), .O_BUF_DATA(bd));
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic t_cfg;
        chk("gain_rst", 2'h0, gain);
        for (int m = 0; m < 8; m++)
        begin
            mode = m[2:0];
            wt(1);
            chk("rx", m == 3, rxa);
        end
        mode = 3'h3;
        for (int g = 3; g >= 0; g--)
        begin
            gsel = g[1:0];
            gwr = 1;
            wt(1);
            gwr = 0;
            chk("gain", g[1:0], gain);
        end
        for (int f = 0; f < 2; f++)
        begin
            cfe = f[0];
            wt(1);
            chk("poly_low", {f[0], ~f[0]}, {pol, low});
        end
        $display("test cfg done");
    endtask
    // Period between result steps under a level step equals the sample tick
    task automatic t_rate(input logic o, input logic [7:0] dv, input int e);
        logic [7:0] r;
        int n;
        ook = o;
        devt = dv;
        lvl = 8'h00;
        wt(300);
        lvl = 8'hF0;
        for (int k = 0; k < 2; k++)
        begin
            r = res;
            n = 0;
            while (res === r && n < 200)
            begin
                wt(1);
                n++;
            end
        end
        chk("tick", e[15:0], n[15:0]);
        $display("test rate done");
    endtask
    task automatic t_level;
        ook = 0;
        devt = 8'h00;
        lvl = 8'h40;
        wt(80);
        chk("avg", 8'h40, res);
        thr = 8'h40;
        ra = 1;
        wt(10);
        chk("equal", 0, sts);
        thr = 8'h3F;
        wt(4);
        chk("set_pins", 3'b110, {sts, pa, pb});
        ra = 0;
        rb = 1;
        thr = 8'h40;
        wt(20);
        chk("sticky_pins", 3'b101, {sts, pa, pb});
        clrq = 1;
        wt(1);
        clrq = 0;
        wt(3);
        chk("clear", 0, sts);
        $display("test level done");
    endtask
    task automatic t_data;
        logic d;
        int n;
        cont = 1;
        raw = 1;
        wt(200);
        d = dat;
        rev = 1;
        wt(200);
        chk("raw", !d, dat);
        rev = 0;
        raw = 0;
        wt(200);
        chk("sync", 1, dat);
        n = 0;
        while (dclk !== 1 && n < 70)
        begin
            wt(1);
            n++;
        end
        chk("dclk", 1, dclk);
        cont = 0;
        raw = 0;
        wt(11000);
        brd = 1;
        n = 0;
        while (bv === 1 && n < 40)
        begin
            if (n > 0)
                chk("buf_data", 8'hFF, bd);
            n++;
            wt(1);
        end
        brd = 0;
        chk("buf_fill", 1, n >= 16 && n <= 17);
        $display("test data done");
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        stop_test();
    end
    initial
    begin
        wt(8);
        rst_n = 1;
        wt(1);
        t_cfg();
        t_rate(1, 8'h00, 8);
        t_rate(0, 8'h01, 4);
        t_level();
        t_data();
        stop_test();
    end
endmodule
`default_nettype wire
